/* File: hdl/pbc_pkg.sv */
package pbc_pkg;
    localparam int unsigned REG_W        = 16;
    localparam int unsigned IDX_W        = 5;
    // Register indices.
    localparam logic [4:0]  IDX_BCTL     = 5'h00;
    localparam logic [4:0]  IDX_BSTAT    = 5'h01;
    localparam logic [4:0]  IDX_ID1      = 5'h02;
    localparam logic [4:0]  IDX_ID2      = 5'h03;
    localparam logic [4:0]  IDX_ANADV    = 5'h04;
    localparam logic [4:0]  IDX_ANLPA    = 5'h05;
    localparam logic [4:0]  IDX_ANEXP    = 5'h06;
    localparam logic [4:0]  IDX_MODE     = 5'h11;
    localparam logic [4:0]  IDX_SMODE    = 5'h12;
    localparam logic [4:0]  IDX_SIND     = 5'h1B;
    localparam logic [4:0]  IDX_ISRC     = 5'h1D;
    localparam logic [4:0]  IDX_IMASK    = 5'h1E;
    localparam logic [4:0]  IDX_SCTL     = 5'h1F;
    // Basic control field positions, plus the autoneg-done bit of basic status.
    localparam int unsigned B_RESET      = 15;
    localparam int unsigned B_LOOP       = 14;
    localparam int unsigned B_SPEED      = 13;
    localparam int unsigned B_ANEN       = 12;
    localparam int unsigned B_PDOWN      = 11;
    localparam int unsigned B_RESTART    = 9;
    localparam int unsigned B_DUPLEX     = 8;
    localparam int unsigned B_COLTEST    = 7;
    localparam int unsigned B_ANDONE     = 5;
    // Mask of the bits software may store in basic control.
    localparam logic [15:0] BCTL_RW_MASK = 16'h7980;
    // Cycles the internal soft reset is held.
    localparam int unsigned SRST_CYC     = 4;
endpackage

/* File: hdl/pbc_regfile.sv */
`timescale 1ns/1ns
// Small storage for the other implemented indices; read data is registered.
module pbc_regfile #(
    parameter int unsigned DW = 16,
    parameter int unsigned AW = 5
) (
    input  wire logic          clk,    // System clock.
    input  wire logic          rst_n,  // Async reset, active low.
    input  wire logic          clr,    // Synchronous clear (soft reset).
    input  wire logic          we,     // Write strobe.
    input  wire logic [AW-1:0] waddr,  // Write index.
    input  wire logic [DW-1:0] wdata,  // Write data.
    input  wire logic [AW-1:0] raddr,  // Read index.
    output logic      [DW-1:0] rdata   // Registered read data.
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] next_rdata;

    always_comb begin
        next_rdata = mem[raddr];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2**AW; g++) begin : g_word
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem[g] <= '0;
                end else if (clr) begin
                    mem[g] <= '0;
                end else if (we && waddr == AW'(g)) begin
                    mem[g] <= wdata;
                end
            end
        end
    endgenerate
endmodule

/* File: hdl/pbc_ctrl.sv */
`timescale 1ns/1ns
// Overview of operation
// R1: Registers reached only through indirect management access.
// R2: Sixteen-bit registers; basic control is index zero.
// R3: Indices 0-6,17,18,27,29,30,31 are implemented.
// R4: Kept fields survive only bit-15 soft reset.
// R5: Bit 15 starts soft reset, self clears.
// R6: Host writes nothing else with reset bit.
// R7: Bit 14 selects loopback, resets to zero.
// R8: Bit 13 speed, ignored under auto-negotiation.
// R9: Bit 12 enables auto-negotiation, overriding manual.
// R10: Speed and autoneg defaults follow strap.
// R11: Bit 11 power-down; completion sets status bit 5.
// R12: Bit 9 restarts autoneg, self clears.
// R13: Bit 8 duplex, reset zero, ignored under autoneg.
// R14: Bit 7 enables collision test, reset zero.
// R15: Reserved bits and unlisted indices read zero.
module pbc_ctrl
    import pbc_pkg::*;
(
    input  wire logic                     clk,          // 50 MHz clock.
    input  wire logic                     rst_n,        // Async reset, active low.
    input  wire logic                     speed_strap,  // Speed-select strap pin.
    input  wire logic                     mgmt_req,     // Access strobe, one cycle.
    input  wire logic                     mgmt_wr,      // 1 = write, 0 = read.
    input  wire logic [pbc_pkg::IDX_W-1:0] mgmt_idx,    // Register index.
    input  wire logic [pbc_pkg::REG_W-1:0] mgmt_wdata,  // Write data.
    input  wire logic                     an_done_in,   // Autoneg finished, from the PHY core.
    output logic                          mgmt_ack,     // Access done, one cycle.
    output logic      [pbc_pkg::REG_W-1:0] mgmt_rdata,  // Read data, valid with ack.
    output logic                          phy_srst,     // Internal soft reset active.
    output logic                          loopback,     // Loopback mode.
    output logic                          speed_100,    // Effective manual 100 Mb/s.
    output logic                          full_duplex,  // Effective manual full duplex.
    output logic                          an_enable,    // Auto-negotiation enabled.
    output logic                          an_restart,   // Restart pulse, one cycle.
    output logic                          power_down,   // General power down.
    output logic                          col_test      // Collision test enable.
);
    import pbc_pkg::*;

    // Strap and autoneg-done synchronisers; each first stage feeds only its second.
    logic sync1;
    logic sync2;
    logic an_s1;
    logic an_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            an_s1 <= 1'b0;
            an_s2 <= 1'b0;
        end else begin
            sync1 <= speed_strap;
            sync2 <= sync1;
            an_s1 <= an_done_in;
            an_s2 <= an_s1;
        end
    end

    // Strap is captured after reset release, past the synchroniser, and again during each soft reset.
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic       strap_ok;
    logic       next_strap_ok;
    logic       ctl_loop, ctl_speed, ctl_anen, ctl_pd, ctl_dup, ctl_col;
    logic       next_loop, next_speed, next_anen, next_pd, next_dup, next_col;
    logic       restart_q, next_restart;
    logic       andone, next_andone;
    logic [2:0] srst_cnt, next_srst_cnt;
    logic       ack_q, next_ack;
    logic       rd_bctl, next_rd_bctl, rd_bstat, next_rd_bstat, rd_file, next_rd_file;
    logic       hit, file_hit, wr_bctl, srst_done;
    logic [REG_W-1:0] bctl_val, bstat_val, file_rdata;

    always_comb begin
        unique case (mgmt_idx) // R3
            IDX_ID1, IDX_ID2, IDX_ANADV, IDX_ANLPA, IDX_ANEXP, IDX_MODE, IDX_SMODE,
            IDX_SIND, IDX_ISRC, IDX_IMASK, IDX_SCTL: file_hit = 1'b1;
            default: file_hit = 1'b0;
        endcase
        hit       = file_hit || mgmt_idx == IDX_BCTL || mgmt_idx == IDX_BSTAT;
        wr_bctl   = mgmt_req && mgmt_wr && mgmt_idx == IDX_BCTL; // R1 R2
        srst_done = srst_cnt == 3'(1);
    end

    always_comb begin
        next_strap_cnt = strap_cnt;
        next_strap_ok  = strap_ok;
        next_loop      = ctl_loop;
        next_speed     = ctl_speed;
        next_anen      = ctl_anen;
        next_pd        = ctl_pd;
        next_dup       = ctl_dup;
        next_col       = ctl_col;
        next_restart   = 1'b0;
        next_andone    = andone;
        next_srst_cnt  = srst_cnt;
        if (!strap_ok) begin
            next_strap_cnt = strap_cnt + 2'(1);
            if (strap_cnt == 2'(2)) begin
                next_strap_ok = 1'b1;
                next_speed    = sync2; // R10
                next_anen     = sync2; // R10
            end
        end
        if (srst_cnt != 3'(0)) begin
            next_srst_cnt = srst_cnt - 3'(1);
            // No kept-over-soft-reset fields live here, so all clear except speed and autoneg, which reload the strap. R4
            next_loop   = 1'b0;
            next_pd     = 1'b0;
            next_dup    = 1'b0;
            next_col    = 1'b0;
            next_andone = 1'b0;
            next_speed  = sync2; // R10
            next_anen   = sync2;
        end else if (wr_bctl) begin
            if (mgmt_wdata[B_RESET]) begin
                next_srst_cnt = 3'(SRST_CYC); // R5 R6
            end else begin
                next_loop    = mgmt_wdata[B_LOOP];    // R7
                next_speed   = mgmt_wdata[B_SPEED];   // R8
                next_anen    = mgmt_wdata[B_ANEN];    // R9
                next_pd      = mgmt_wdata[B_PDOWN];   // R11
                next_dup     = mgmt_wdata[B_DUPLEX];  // R13
                next_col     = mgmt_wdata[B_COLTEST]; // R14
                next_restart = mgmt_wdata[B_RESTART] && mgmt_wdata[B_ANEN]; // R12
                if (mgmt_wdata[B_RESTART] || mgmt_wdata[B_PDOWN]) begin
                    next_andone = 1'b0;
                end
            end
        end else if (an_s2 && ctl_anen && !ctl_pd) begin
            next_andone = 1'b1; // R11
        end
    end

    always_comb begin
        bctl_val           = '0; // R15
        bctl_val[B_RESET]  = srst_cnt != 3'(0); // R5
        bctl_val[B_LOOP]   = ctl_loop;
        bctl_val[B_SPEED]  = ctl_speed;
        bctl_val[B_ANEN]   = ctl_anen;
        bctl_val[B_PDOWN]  = ctl_pd;
        bctl_val[B_DUPLEX] = ctl_dup;
        bctl_val[B_COLTEST] = ctl_col;
        bctl_val           = bctl_val & (BCTL_RW_MASK | (16'h0001 << B_RESET));
        bstat_val          = '0;
        bstat_val[B_ANDONE] = andone;
        next_ack       = mgmt_req;
        next_rd_bctl   = mgmt_idx == IDX_BCTL;
        next_rd_bstat  = mgmt_idx == IDX_BSTAT;
        next_rd_file   = file_hit;
    end

    pbc_regfile #(.DW(REG_W), .AW(IDX_W)) u_file (
        .clk   (clk),
        .rst_n (rst_n),
        .clr   (srst_done),
        .we    (mgmt_req && mgmt_wr && file_hit && srst_cnt == 3'(0)),
        .waddr (mgmt_idx),
        .wdata (mgmt_wdata),
        .raddr (mgmt_idx),
        .rdata (file_rdata)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt <= '0;
            strap_ok  <= 1'b0;
            ctl_loop  <= 1'b0;
            ctl_speed <= 1'b0;
            ctl_anen  <= 1'b0;
            ctl_pd    <= 1'b0;
            ctl_dup   <= 1'b0;
            ctl_col   <= 1'b0;
            restart_q <= 1'b0;
            andone    <= 1'b0;
            srst_cnt  <= '0;
            ack_q     <= 1'b0;
            rd_bctl   <= 1'b0;
            rd_bstat  <= 1'b0;
            rd_file   <= 1'b0;
        end else begin
            strap_cnt <= next_strap_cnt;
            strap_ok  <= next_strap_ok;
            ctl_loop  <= next_loop;
            ctl_speed <= next_speed;
            ctl_anen  <= next_anen;
            ctl_pd    <= next_pd;
            ctl_dup   <= next_dup;
            ctl_col   <= next_col;
            restart_q <= next_restart;
            andone    <= next_andone;
            srst_cnt  <= next_srst_cnt;
            ack_q     <= next_ack;
            rd_bctl   <= next_rd_bctl;
            rd_bstat  <= next_rd_bstat;
            rd_file   <= next_rd_file;
        end
    end

    // Read data is built from registered selects so the port comes from flops.
    logic [REG_W-1:0] next_rdata;
    logic [REG_W-1:0] bctl_q, bstat_q;
    // Read data only moves with an acknowledge, so idle index lines cannot disturb it.
    always_comb begin
        next_rdata = mgmt_rdata;
        if (ack_q) begin
            next_rdata = '0; // R15
            if (rd_bctl) begin
                next_rdata = bctl_q;
            end else if (rd_bstat) begin
                next_rdata = bstat_q;
            end else if (rd_file) begin
                next_rdata = file_rdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bctl_q      <= '0;
            bstat_q     <= '0;
            mgmt_rdata  <= '0;
            mgmt_ack    <= 1'b0;
            phy_srst    <= 1'b0;
            loopback    <= 1'b0;
            speed_100   <= 1'b0;
            full_duplex <= 1'b0;
            an_enable   <= 1'b0;
            an_restart  <= 1'b0;
            power_down  <= 1'b0;
            col_test    <= 1'b0;
        end else begin
            bctl_q      <= bctl_val;
            bstat_q     <= bstat_val;
            mgmt_rdata  <= next_rdata;
            mgmt_ack    <= ack_q;
            phy_srst    <= next_srst_cnt != 3'(0);
            loopback    <= next_loop;
            speed_100   <= next_speed && !next_anen; // R8
            full_duplex <= next_dup && !next_anen;   // R9 R13
            an_enable   <= next_anen;
            an_restart  <= next_restart;
            power_down  <= next_pd;
            col_test    <= next_col;
        end
    end

    property p_srst_self_clear;
        @(posedge clk) disable iff (!rst_n)
        (wr_bctl && mgmt_wdata[B_RESET] && srst_cnt == 3'(0)) |=> phy_srst [*4] ##1 !phy_srst;
    endproperty
    a_srst_self_clear: assert property (p_srst_self_clear) else $error("soft reset len"); // R5

    property p_loop_follow;
        @(posedge clk) disable iff (!rst_n)
        (wr_bctl && !mgmt_wdata[B_RESET] && srst_cnt == 3'(0)) |=> loopback == $past(mgmt_wdata[B_LOOP]);
    endproperty
    a_loop_follow: assert property (p_loop_follow) else $error("loopback wrong"); // R7

    property p_speed_ignored;
        @(posedge clk) disable iff (!rst_n) an_enable |-> !speed_100 && !full_duplex;
    endproperty
    a_speed_ignored: assert property (p_speed_ignored) else $error("manual under autoneg"); // R8

    property p_restart_pulse;
        @(posedge clk) disable iff (!rst_n)
        (an_restart && !(wr_bctl && mgmt_wdata[B_RESTART])) |=> !an_restart;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart stuck"); // R12

    property p_srst_clears;
        @(posedge clk) disable iff (!rst_n) $fell(phy_srst) |-> !loopback && !col_test && !power_down;
    endproperty
    a_srst_clears: assert property (p_srst_clears) else $error("fields kept"); // R4

    property p_unlisted_zero;
        @(posedge clk) disable iff (!rst_n)
        (mgmt_req && !hit) |-> ##2 (mgmt_ack && mgmt_rdata == '0);
    endproperty
    a_unlisted_zero: assert property (p_unlisted_zero) else $error("unlisted nonzero"); // R15

    property p_ack_latency;
        @(posedge clk) disable iff (!rst_n) mgmt_req |-> ##2 mgmt_ack;
    endproperty
    a_ack_latency: assert property (p_ack_latency) else $error("ack late"); // R1

    property p_andone_power;
        @(posedge clk) disable iff (!rst_n) power_down |=> !$rose(andone);
    endproperty
    a_andone_power: assert property (p_andone_power) else $error("done in power down"); // R11
endmodule

/* File: sim/pbc_host.sv */
`timescale 1ns/1ns
// Host software model: reaches the registers only by index through the management strobe.
module pbc_host (
    input  wire logic        clk,         // Bench clock.
    input  wire logic        mgmt_ack,    // Access done.
    input  wire logic [15:0] mgmt_rdata,  // Read data.
    output logic             mgmt_req,    // Access strobe.
    output logic             mgmt_wr,     // Write select.
    output logic      [4:0]  mgmt_idx,    // Register index.
    output logic      [15:0] mgmt_wdata,  // Write data.
    output logic             timed_out    // An access saw no ack.
);
    initial begin
        mgmt_req = 1'b0;
        mgmt_wr = 1'b0;
        mgmt_idx = 5'h00;
        mgmt_wdata = 16'h0000;
        timed_out = 1'b0;
    end
    task automatic acc(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                       output logic [15:0] rd);
        int n;
        @(posedge clk);
        mgmt_req <= 1'b1;
        mgmt_wr <= wr;
        mgmt_idx <= idx;
        mgmt_wdata <= wd;
        @(posedge clk);
        mgmt_req <= 1'b0;
        // Released lines carry inverted junk so a stale index can never be trusted.
        mgmt_wr <= ~wr;
        mgmt_idx <= ~idx;
        mgmt_wdata <= ~wd;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (mgmt_ack !== 1'b1 && n < 8);
        if (n >= 8) timed_out = 1'b1;
        rd = mgmt_rdata;
    endtask
    // Only bit 15 is set, so no other control field races the reset.
    task automatic soft_reset();
        logic [15:0] d;
        acc(1'b1, 5'h00, 16'h8000, d);
    endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
    import pbc_pkg::*;
    logic        clk, rst_n, speed_strap, an_done_in, mgmt_req, mgmt_wr, mgmt_ack;
    logic        phy_srst, loopback, speed_100, full_duplex, an_enable, an_restart;
    logic        power_down, col_test, timed_out;
    logic [4:0]  mgmt_idx;
    logic [15:0] mgmt_wdata, mgmt_rdata, rd, w, ctl_m;
    logic [4:0]  idx_tab [14] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h11, 5'h12, 5'h1B,
                                  5'h1D, 5'h1E, 5'h1F, 5'h07, 5'h10, 5'h1C};
    int          err_total = 0, num_checks = 0, restarts = 0, exp_restarts = 0, n;
    int          srst_hi = 0;
    pbc_ctrl dut (.clk, .rst_n, .speed_strap, .mgmt_req, .mgmt_wr, .mgmt_idx, .mgmt_wdata,
                  .an_done_in, .mgmt_ack, .mgmt_rdata, .phy_srst, .loopback, .speed_100,
                  .full_duplex, .an_enable, .an_restart, .power_down, .col_test);
    pbc_host host (.clk, .mgmt_ack, .mgmt_rdata, .mgmt_req, .mgmt_wr, .mgmt_idx, .mgmt_wdata,
                   .timed_out);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        if (an_restart === 1'b1) restarts <= restarts + 1;
        if (phy_srst === 1'b1) srst_hi <= srst_hi + 1;
    end
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // The whole sequence needs about two hundred cycles; fifteen times that means a hang.
    initial begin
        #(20 * 3000);
        err_total++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0;
        an_done_in = 1'b0;
        void'($urandom(32'h4B79));
        speed_strap = 1'($urandom());
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ctl_m = {2'b00, speed_strap, speed_strap, 12'h000};
        host.acc(1'b0, IDX_BCTL, 16'h0000, rd);
        `CHK(rd, ctl_m)
        `CHK({an_enable, speed_100, loopback, col_test}, {speed_strap, 3'b000})
        $display("test defaults done");
        for (int i = 0; i < 12; i++) begin
            w = (i == 0) ? 16'h1200 : 16'($urandom()) & 16'h7FFF;
            host.acc(1'b1, IDX_BCTL, w, rd);
            ctl_m = w & BCTL_RW_MASK;
            if (w[9] && w[12]) exp_restarts++;
            host.acc(1'b0, IDX_BCTL, 16'h0000, rd);
            `CHK(rd, ctl_m)
            `CHK({loopback, power_down, col_test}, {w[14], w[11], w[7]})
            `CHK(an_enable, w[12])
            `CHK({speed_100, full_duplex}, {w[13] & ~w[12], w[8] & ~w[12]})
        end
        `CHK(restarts, exp_restarts)
        $display("test control writes done");
        for (int i = 0; i < 14; i++) begin
            w = 16'($urandom());
            host.acc(1'b1, idx_tab[i], w, rd);
            host.acc(1'b0, idx_tab[i], 16'h0000, rd);
            `CHK(rd, (i < 11) ? w : 16'h0000)
        end
        $display("test index map done");
        host.soft_reset();
        `CHK(phy_srst, 1'b1)
        // A write that lands while the soft reset runs must be dropped.
        host.acc(1'b1, IDX_BCTL, 16'h4080, rd);
        n = 0;
        while (phy_srst === 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(srst_hi, SRST_CYC)
        host.acc(1'b0, IDX_BCTL, 16'h0000, rd);
        `CHK(rd, {2'b00, speed_strap, speed_strap, 12'h000})
        `CHK({loopback, col_test}, 2'b00)
        host.acc(1'b0, IDX_ANADV, 16'h0000, rd);
        `CHK(rd, 16'h0000)
        $display("test soft reset done");
        host.acc(1'b1, IDX_BCTL, 16'h1000, rd);
        @(posedge clk);
        an_done_in <= 1'b1;
        repeat (4) @(posedge clk);
        host.acc(1'b0, IDX_BSTAT, 16'h0000, rd);
        `CHK(rd[B_ANDONE], 1'b1)
        host.acc(1'b1, IDX_BCTL, 16'h1800, rd);
        host.acc(1'b0, IDX_BSTAT, 16'h0000, rd);
        `CHK({rd[B_ANDONE], power_down}, 2'b01)
        an_done_in <= 1'b0;
        `CHK(timed_out, 1'b0)
        $display("test autoneg done");
        give_verdict();
    end
endmodule
